// ### src/dmactl_channel.sv
// Single DMA channel control: status, request, mask, mode and transfer sequencing
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module dmactl_channel #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Transfer request and end-of-process pins
  input  wire logic                   xfer_request,
  input  wire logic                   ext_end_of_process,
  // System bus ownership
  output logic                        bus_request,
  input  wire logic                   bus_grant,
  // Transfer side
  output logic [15:0]                 xfer_address,
  output dmactl_pkg::dmactl_strobe_t  xfer_strobes,
  output logic                        end_of_process
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_BUS, ST_XFER} dmactl_state_t;

  dmactl_state_t            state;
  dmactl_state_t            next_state;
  dmactl_pkg::dmactl_mode_t mode;
  logic [15:0]              base_addr;
  logic [15:0]              base_count;
  logic [15:0]              current_address;
  logic [15:0]              current_word_count;
  logic                     mask;
  logic                     soft_service_request;
  logic                     count_reached_flag;
  logic [1:0]               req_sync;
  logic [1:0]               eop_sync;
  logic [1:0]               grant_sync;
  logic [3:0]               rd_index;

  // Pin synchronisers; only the second stage (bit 1) is read by logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_sync   <= 2'h0;
      eop_sync   <= 2'h0;
      grant_sync <= 2'h0;
    end else begin
      req_sync   <= {req_sync[0], xfer_request};
      eop_sync   <= {eop_sync[0], ext_end_of_process};
      grant_sync <= {grant_sync[0], bus_grant};
    end
  end

  // Register bus decode
  wire logic [3:0] wr_idx   = s_axi_awaddr[5:2];
  wire logic [3:0] rd_idx   = s_axi_araddr[5:2];
  wire logic       wr_hi_ok = (s_axi_awaddr >> 6) == '0;
  wire logic       rd_hi_ok = (s_axi_araddr >> 6) == '0;
  wire logic       wr_fire  = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  wire logic       rd_fire  = s_axi_arvalid && s_axi_arready;
  wire logic       wr_map   = wr_hi_ok && (wr_idx == dmactl_pkg::IDX_CUR_ADDR
                              || wr_idx == dmactl_pkg::IDX_CUR_COUNT
                              || wr_idx == dmactl_pkg::IDX_SOFT_REQ
                              || wr_idx == dmactl_pkg::IDX_MASK_SINGLE
                              || wr_idx == dmactl_pkg::IDX_MODE
                              || wr_idx == dmactl_pkg::IDX_MASTER_CLEAR
                              || wr_idx == dmactl_pkg::IDX_CLEAR_MASK
                              || wr_idx == dmactl_pkg::IDX_MASK_ALL);
  wire logic       rd_map   = rd_hi_ok && (rd_idx == dmactl_pkg::IDX_CUR_ADDR
                              || rd_idx == dmactl_pkg::IDX_CUR_COUNT
                              || rd_idx == dmactl_pkg::IDX_STATUS);
  wire logic       wr_ok    = wr_fire && wr_map;
  wire logic       lane0    = s_axi_wstrb[0];
  wire logic       wr_base_addr  = wr_ok && wr_idx == dmactl_pkg::IDX_CUR_ADDR && state == ST_IDLE;
  wire logic       wr_base_count = wr_ok && wr_idx == dmactl_pkg::IDX_CUR_COUNT && state == ST_IDLE;
  wire logic       wr_soft   = wr_ok && lane0 && wr_idx == dmactl_pkg::IDX_SOFT_REQ;
  wire logic       wr_mask1  = wr_ok && lane0 && wr_idx == dmactl_pkg::IDX_MASK_SINGLE;
  wire logic       wr_maska  = wr_ok && lane0 && wr_idx == dmactl_pkg::IDX_MASK_ALL;
  wire logic       wr_mode   = wr_ok && lane0 && wr_idx == dmactl_pkg::IDX_MODE;
  wire logic       mclear    = wr_ok && wr_idx == dmactl_pkg::IDX_MASTER_CLEAR;
  wire logic       wr_unmask = wr_ok && wr_idx == dmactl_pkg::IDX_CLEAR_MASK;
  wire logic       soft_set  = wr_soft && s_axi_wdata[dmactl_pkg::SOFT_REQ_BIT];

  // Request and transfer decode
  wire logic hw_request = req_sync[1] && !mask;
  wire logic valid_req  = hw_request || soft_service_request;
  wire logic mode_ok    = mode.service_mode_field != dmactl_pkg::SVC_RSVD;
  wire logic step       = state == ST_XFER;
  wire logic tc         = step && current_word_count == dmactl_pkg::WORD_RESET;
  wire logic eop        = tc || eop_sync[1];
  wire logic is_single  = mode.service_mode_field == dmactl_pkg::SVC_SINGLE;
  wire logic is_demand  = mode.service_mode_field == dmactl_pkg::SVC_DEMAND;
  wire logic do_reload  = eop && mode.auto_reload_enable;
  wire logic moves      = mode.transfer_type_field == dmactl_pkg::TT_WRITE
                       || mode.transfer_type_field == dmactl_pkg::TT_READ;
  wire logic [15:0] stepped_addr = mode.address_direction ? current_address - 16'h0001
                                                          : current_address + 16'h0001;
  wire logic [15:0] lane_addr  = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : base_addr[15:8],
                                  lane0 ? s_axi_wdata[7:0] : base_addr[7:0]};
  wire logic [15:0] lane_count = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : base_count[15:8],
                                  lane0 ? s_axi_wdata[7:0] : base_count[7:0]};
  wire logic [31:0] rd_value =
    (rd_idx == dmactl_pkg::IDX_CUR_ADDR)  ? {16'h0000, current_address} :
    (rd_idx == dmactl_pkg::IDX_CUR_COUNT) ? {16'h0000, current_word_count} :
    (rd_idx == dmactl_pkg::IDX_STATUS)    ?
      (32'(valid_req) << dmactl_pkg::STAT_REQ_BIT) |
      (32'(count_reached_flag) << dmactl_pkg::STAT_CTC_BIT) : 32'h0000_0000;

  // Service sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (valid_req && mode_ok) begin
          next_state = ST_WAIT_BUS;
        end
      end
      ST_WAIT_BUS: begin
        if (!valid_req) begin
          next_state = ST_IDLE;
        end else if (grant_sync[1]) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (eop || is_single) begin
          next_state = ST_IDLE;
        end else if (is_demand && !valid_req) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (mclear) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Verify and the illegal code keep every strobe low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_strobes   <= '0;
      bus_request    <= 1'h0;
      end_of_process <= 1'h0;
    end else begin
      xfer_strobes.xfer_ack         <= next_state == ST_XFER && moves;
      xfer_strobes.mem_write_strobe <= next_state == ST_XFER
                                    && mode.transfer_type_field == dmactl_pkg::TT_WRITE;
      xfer_strobes.mem_read_strobe  <= next_state == ST_XFER
                                    && mode.transfer_type_field == dmactl_pkg::TT_READ;
      bus_request    <= next_state != ST_IDLE;
      end_of_process <= eop;
    end
  end

  // Address and count; intermediate values stay put between services
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_addr          <= dmactl_pkg::WORD_RESET;
      base_count         <= dmactl_pkg::WORD_RESET;
      current_address    <= dmactl_pkg::WORD_RESET;
      current_word_count <= dmactl_pkg::WORD_RESET;
    end else if (do_reload) begin
      current_address    <= base_addr;
      current_word_count <= base_count;
    end else if (step) begin
      current_address    <= stepped_addr;
      current_word_count <= current_word_count - 16'h0001;
    end else begin
      if (wr_base_addr) begin
        base_addr       <= lane_addr;
        current_address <= lane_addr;
      end
      if (wr_base_count) begin
        base_count         <= lane_count;
        current_word_count <= lane_count;
      end
    end
  end

  // Control flags; a hardware set wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode                 <= dmactl_pkg::MODE_RESET;
      mask                 <= dmactl_pkg::MASK_RESET;
      soft_service_request <= 1'h0;
      count_reached_flag   <= 1'h0;
    end else begin
      if (wr_mode) begin
        mode <= s_axi_wdata[7:0];
      end
      if ((eop && !mode.auto_reload_enable) || mclear) begin
        mask <= 1'h1;
      end else if (wr_mask1) begin
        mask <= s_axi_wdata[dmactl_pkg::MASK_SET_BIT];
      end else if (wr_maska) begin
        mask <= s_axi_wdata[dmactl_pkg::MASK_ALL_BIT];
      end else if (wr_unmask) begin
        mask <= 1'h0;
      end
      if (soft_set) begin
        soft_service_request <= 1'h1;
      end else if (eop || mclear || wr_soft) begin
        soft_service_request <= 1'h0;
      end
      if (eop) begin
        count_reached_flag <= 1'h1;
      end else if (mclear) begin
        count_reached_flag <= 1'h0;
      end
    end
  end

  // AXI4-Lite slave; address and data are taken together in one handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= dmactl_pkg::RESP_OKAY;
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rresp   <= dmactl_pkg::RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      rd_index      <= 4'h0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= wr_map ? dmactl_pkg::RESP_OKAY : dmactl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rdata  <= rd_map ? rd_value : 32'h0000_0000;
        s_axi_rresp  <= rd_map ? dmactl_pkg::RESP_OKAY : dmactl_pkg::RESP_SLVERR;
        rd_index     <= rd_idx;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end

  assign xfer_address = current_address;

  default clocking dmactl_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter_xfer;
    state == ST_WAIT_BUS && valid_req && grant_sync[1] && !mclear;
  endsequence

  sequence s_one_step;
    state == ST_XFER ##1 state != ST_XFER;
  endsequence

  a_status_req_bit: assert property ($rose(s_axi_rvalid)
    && rd_index == dmactl_pkg::IDX_STATUS |-> s_axi_rdata[4] == $past(valid_req))
    else $error("status request bit wrong");
  a_ctc_sets: assert property (eop |=> count_reached_flag)
    else $error("count reached flag not set");
  a_soft_clears: assert property (eop && !soft_set |=> !soft_service_request)
    else $error("software request not cleared");
  a_mask_blocks: assert property (state == ST_IDLE && mask && !soft_service_request
    |=> !bus_request) else $error("masked request passed");
  a_mask_auto_set: assert property (eop && !mode.auto_reload_enable |=> mask)
    else $error("mask not set after end of process");
  a_reset_masked: assert property ($rose(aresetn) |-> mask && !valid_req)
    else $error("request accepted after reset");
  a_bus_request: assert property (state == ST_IDLE && valid_req && mode_ok && !mclear
    |=> bus_request ##0 state == ST_WAIT_BUS) else $error("bus not requested");
  a_single_once: assert property (s_enter_xfer ##0 is_single |=> s_one_step)
    else $error("single mode did not stop");
  a_tc_wraps: assert property (tc && !mode.auto_reload_enable
    |=> current_word_count == dmactl_pkg::COUNT_WRAP) else $error("count did not wrap");
  a_auto_reload: assert property (do_reload |=> current_word_count == $past(base_count)
    && current_address == $past(base_addr)) else $error("auto reload missed");
  a_base_frozen: assert property (state != ST_IDLE && !$rose(state != ST_IDLE)
    |-> $stable(base_count) && $stable(base_addr)) else $error("base changed in service");
  a_addr_direction: assert property (step && !do_reload |=> current_address ==
    ($past(mode.address_direction) ? $past(current_address) - 16'h0001
                                   : $past(current_address) + 16'h0001))
    else $error("address stepped wrong way");
  a_verify_quiet: assert property (xfer_strobes.mem_write_strobe
    || xfer_strobes.mem_read_strobe |-> $past(moves)) else $error("strobe during verify");
  a_rsvd_no_start: assert property (state == ST_IDLE && !mode_ok |=> state == ST_IDLE)
    else $error("reserved mode started");
  a_master_clear: assert property (mclear |=> state == ST_IDLE && mask
    && (!count_reached_flag || $past(eop))) else $error("master clear incomplete");

endmodule

// ### src/dmactl_pkg.sv
// Shared constants, field layouts and carrier types for the DMA channel control block
package dmactl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CUR_ADDR     = 4'h0;
  localparam logic [3:0] IDX_CUR_COUNT    = 4'h1;
  localparam logic [3:0] IDX_STATUS       = 4'h8;
  localparam logic [3:0] IDX_SOFT_REQ     = 4'h9;
  localparam logic [3:0] IDX_MASK_SINGLE  = 4'hA;
  localparam logic [3:0] IDX_MODE         = 4'hB;
  localparam logic [3:0] IDX_MASTER_CLEAR = 4'hD;
  localparam logic [3:0] IDX_CLEAR_MASK   = 4'hE;
  localparam logic [3:0] IDX_MASK_ALL     = 4'hF;

  // Field positions
  localparam int STAT_REQ_BIT  = 4;
  localparam int STAT_CTC_BIT  = 0;
  localparam int SOFT_REQ_BIT  = 2;
  localparam int MASK_SET_BIT  = 2;
  localparam int MASK_ALL_BIT  = 0;

  // Reset values and the count wrap value
  localparam logic        MASK_RESET  = 1'h1;
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_WRAP  = 16'hFFFF;

  // Service modes
  localparam logic [1:0] SVC_DEMAND = 2'h0;
  localparam logic [1:0] SVC_SINGLE = 2'h1;
  localparam logic [1:0] SVC_BLOCK  = 2'h2;
  localparam logic [1:0] SVC_RSVD   = 2'h3;

  // Transfer types
  localparam logic [1:0] TT_VERIFY  = 2'h0;
  localparam logic [1:0] TT_WRITE   = 2'h1;
  localparam logic [1:0] TT_READ    = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] service_mode_field;
    logic       address_direction;
    logic       auto_reload_enable;
    logic [1:0] transfer_type_field;
    logic [1:0] unused;
  } dmactl_mode_t;

  typedef struct packed {
    logic mem_write_strobe;
    logic mem_read_strobe;
    logic xfer_ack;
  } dmactl_strobe_t;

endpackage

// ### tb/dmactl_partner.sv
// Behavioural SCSI controller data register and system bus arbiter for the channel bench
`timescale 1ns/1ps
module dmactl_partner #(
  parameter int GRANT_DLY = 3
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Channel side
  input  wire logic       bus_request,
  input  wire logic       xfer_ack,
  output logic            xfer_request,
  output logic            bus_grant,
  // Bench control: words added to the data register this cycle
  input  wire logic [7:0] add_words
);
  logic [7:0] words;
  int         wait_cnt;
  logic       take;

  // Request stands exactly while data is waiting
  assign xfer_request = (words != 8'h00);
  // An acknowledge on an empty register moves nothing, so the count never wraps
  assign take = xfer_ack && (words != 8'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      words <= 8'h00;
      wait_cnt <= 0;
      bus_grant <= 1'b0;
    end else begin
      words <= words + add_words - {7'h00, take};
      if (!bus_request) begin
        wait_cnt <= 0;
        bus_grant <= 1'b0;
      end else if (wait_cnt < GRANT_DLY) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        bus_grant <= 1'b1;
      end
    end
  end
endmodule

// ### tb/single_channel_dma_control_tb.sv
// Self-checking bench for the DMA channel control block
`timescale 1ns/1ps
module single_channel_dma_control_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, xfer_request, bus_request, bus_grant;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] xfer_address, last_addr;
  logic        end_of_process;
  logic [7:0]  add_words = 8'h00;
  logic        ext_eop = 1'b0;
  dmactl_pkg::dmactl_strobe_t xfer_strobes;
  int num_errors = 0, checks = 0, acks = 0, wrs = 0, rds = 0, strb = 0, eops = 0;
  int run = 0, max_run = 0;

  always #4 aclk = ~aclk;

  dmactl_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .xfer_request(xfer_request), .ext_end_of_process(ext_eop), .bus_request(bus_request),
    .bus_grant(bus_grant), .xfer_address(xfer_address), .xfer_strobes(xfer_strobes),
    .end_of_process(end_of_process));

  dmactl_partner #(.GRANT_DLY(3)) far_end (.aclk(aclk), .aresetn(aresetn),
    .bus_request(bus_request), .xfer_ack(xfer_strobes.xfer_ack),
    .xfer_request(xfer_request), .bus_grant(bus_grant), .add_words(add_words));

  // Transfer monitor: counts and run lengths seen at the transfer side
  always @(posedge aclk) begin
    if (xfer_strobes.xfer_ack === 1'b1) begin
      acks <= acks + 1;
      run <= run + 1;
      if (run + 1 > max_run) max_run <= run + 1;
      last_addr <= xfer_address;
    end else run <= 0;
    if (xfer_strobes.mem_write_strobe === 1'b1) wrs <= wrs + 1;
    if (xfer_strobes.mem_read_strobe === 1'b1) rds <= rds + 1;
    if (xfer_strobes !== 3'h0) strb <= strb + 1;
    if (end_of_process === 1'b1) eops <= eops + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d,
                    input logic [1:0] er = dmactl_pkg::RESP_OKAY);
    int n;
    logic a, w;
    n = 0;
    a = 1'b1;
    w = 1'b1;
    // One idle edge keeps bready from being lowered and raised in one step
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((a || w) && n < 50) begin
      @(posedge aclk);
      n++;
      if (a && awready) begin a = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
    end
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 100);
    chk("bvalid", 32'h1, {31'h0, bvalid});
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [3:0] idx, output logic [31:0] d,
                    input logic [1:0] er = dmactl_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 100);
    chk("rvalid", 32'h1, {31'h0, rvalid});
    rready <= 1'b0;
    d = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic rchk(input string nm, input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    rd(idx, d);
    chk(nm, exp, d);
  endtask

  task automatic feed(input logic [7:0] n);
    add_words <= n;
    @(posedge aclk);
    add_words <= 8'h00;
  endtask

  // Bounded wait for the next end-of-process pulse, then let counters settle
  task automatic wait_eop(input int n0);
    int k;
    k = 0;
    while (eops == n0 && k < 500) begin @(posedge aclk); k++; end
    chk("eop seen", 32'h1, {31'h0, eops != n0});
    cyc(3);
  endtask

  task automatic t_after_reset;
    logic [31:0] d;
    rchk("status", dmactl_pkg::IDX_STATUS, 32'h0);
    feed(8'd5);
    cyc(30);
    chk("bus_request masked", 32'h0, {31'h0, bus_request});
    rd(4'h2, d, dmactl_pkg::RESP_SLVERR);
    chk("unmapped data", 32'h0, d);
    wr(dmactl_pkg::IDX_STATUS, 32'h0, dmactl_pkg::RESP_SLVERR);
  endtask

  task automatic t_single;
    logic [31:0] d;
    wr(dmactl_pkg::IDX_CUR_ADDR, 32'h1000);
    wr(dmactl_pkg::IDX_CUR_COUNT, 32'h1);
    wr(dmactl_pkg::IDX_MODE, 32'h44);
    wr(dmactl_pkg::IDX_CLEAR_MASK, 32'h0);
    wait_eop(0);
    cyc(40);
    chk("single acks", 2, acks);
    chk("single run", 1, max_run);
    chk("write strobes", 2, wrs);
    chk("eop pulses", 1, eops);
    chk("last address", 32'h1001, {16'h0, last_addr});
    rchk("count", dmactl_pkg::IDX_CUR_COUNT, 32'hFFFF);
    rchk("address", dmactl_pkg::IDX_CUR_ADDR, 32'h1002);
    rd(dmactl_pkg::IDX_STATUS, d);
    chk("count flag", 32'h1, d & 32'h1);
  endtask

  task automatic t_master_clear;
    logic [31:0] d;
    wr(dmactl_pkg::IDX_MASTER_CLEAR, 32'h0);
    rd(dmactl_pkg::IDX_STATUS, d);
    chk("flag cleared", 32'h0, d & 32'h1);
    cyc(20);
    chk("mask set again", 32'h0, {31'h0, bus_request});
  endtask

  task automatic t_soft_reserved;
    logic [31:0] d;
    wr(dmactl_pkg::IDX_MODE, 32'hC4);
    wr(dmactl_pkg::IDX_SOFT_REQ, 32'h4);
    cyc(20);
    rd(dmactl_pkg::IDX_STATUS, d);
    chk("pending", 32'h10, d & 32'h10);
    chk("reserved mode idle", 32'h0, {31'h0, bus_request});
    wr(dmactl_pkg::IDX_SOFT_REQ, 32'h0);
    rd(dmactl_pkg::IDX_STATUS, d);
    chk("withdrawn", 32'h0, d & 32'h10);
  endtask

  task automatic t_verify;
    int s;
    s = strb;
    wr(dmactl_pkg::IDX_CUR_ADDR, 32'h0050);
    wr(dmactl_pkg::IDX_CUR_COUNT, 32'h0);
    wr(dmactl_pkg::IDX_MODE, 32'h40);
    wr(dmactl_pkg::IDX_SOFT_REQ, 32'h4);
    wait_eop(eops);
    chk("verify strobes", s, strb);
    rchk("verify count", dmactl_pkg::IDX_CUR_COUNT, 32'hFFFF);
    rchk("verify address", dmactl_pkg::IDX_CUR_ADDR, 32'h0051);
    rchk("verify status", dmactl_pkg::IDX_STATUS, 32'h01);
  endtask

  task automatic t_demand;
    int a0, d;
    wr(dmactl_pkg::IDX_MASTER_CLEAR, 32'h0);
    wr(dmactl_pkg::IDX_CUR_ADDR, 32'h3000);
    wr(dmactl_pkg::IDX_CUR_COUNT, 32'h9);
    wr(dmactl_pkg::IDX_MODE, 32'h04);
    a0 = acks;
    wr(dmactl_pkg::IDX_MASK_SINGLE, 32'h0);
    cyc(40);
    d = acks - a0;
    chk("demand paused", 1, (d >= 3 && d < 10));
    rchk("held count", dmactl_pkg::IDX_CUR_COUNT, 32'h9 - d);
    rchk("held address", dmactl_pkg::IDX_CUR_ADDR, 32'h3000 + d);
    rchk("no flag yet", dmactl_pkg::IDX_STATUS, 32'h00);
    // Exactly the words that the rest of the count takes, so the register ends empty
    feed(8'd4);
    wait_eop(eops);
    chk("demand total", 10, acks - a0);
    feed(8'd2);
    cyc(40);
    chk("masked after eop", 10, acks - a0);
  endtask

  task automatic t_block;
    int a0, r0;
    wr(dmactl_pkg::IDX_MASTER_CLEAR, 32'h0);
    wr(dmactl_pkg::IDX_CUR_ADDR, 32'h2000);
    wr(dmactl_pkg::IDX_CUR_COUNT, 32'h3);
    wr(dmactl_pkg::IDX_MODE, 32'hB8);
    max_run = 0;
    a0 = acks;
    r0 = rds;
    // Only two words wait, so the request drops while the block service runs on
    wr(dmactl_pkg::IDX_MASK_SINGLE, 32'h0);
    wait_eop(eops);
    chk("block acks", 4, acks - a0);
    chk("block run", 4, max_run);
    chk("read strobes", 4, rds - r0);
    chk("decrement", 32'h1FFD, {16'h0, last_addr});
    rchk("reload count", dmactl_pkg::IDX_CUR_COUNT, 32'h3);
    rchk("reload address", dmactl_pkg::IDX_CUR_ADDR, 32'h2000);
    rchk("block status", dmactl_pkg::IDX_STATUS, 32'h01);
    feed(8'd1);
    wait_eop(eops);
    chk("mask kept", 8, acks - a0);
  endtask

  task automatic t_ext_eop;
    int a0, e0, n, k;
    a0 = acks;
    k = 0;
    wr(dmactl_pkg::IDX_MASTER_CLEAR, 32'h0);
    wr(dmactl_pkg::IDX_CUR_ADDR, 32'h4000);
    wr(dmactl_pkg::IDX_CUR_COUNT, 32'hFF);
    wr(dmactl_pkg::IDX_MODE, 32'h88);
    wr(dmactl_pkg::IDX_SOFT_REQ, 32'h4);
    while (acks - a0 < 5 && k < 500) begin @(posedge aclk); k++; end
    e0 = eops;
    ext_eop <= 1'b1;
    @(posedge aclk);
    ext_eop <= 1'b0;
    wait_eop(e0);
    n = acks - a0;
    cyc(20);
    chk("ext eop stop", n, acks - a0);
    chk("ext eop early", 1, {31'h0, n >= 5 && n < 16});
    rchk("ext eop count", dmactl_pkg::IDX_CUR_COUNT, 32'hFF - n);
    rchk("ext eop address", dmactl_pkg::IDX_CUR_ADDR, 32'h4000 + n);
    rchk("ext eop status", dmactl_pkg::IDX_STATUS, 32'h01);
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_after_reset();
    t_single();
    t_master_clear();
    t_soft_reserved();
    t_verify();
    t_demand();
    t_block();
    t_ext_eop();
    end_of_test();
  end

  // Whole sequence needs well under a thousand cycles; this is ample headroom
  initial begin
    repeat (30000) @(posedge aclk);
    $display("MISMATCH watchdog expected done seen hang");
    num_errors++;
    end_of_test();
  end
endmodule
